//--- core/insn_pkg.sv
package insn_pkg;

   // ****************************************************************
   // Instruction encodings
   // ****************************************************************

   // Width of one instruction word.
   localparam int unsigned INSN_W = 10;
   // Width of the accumulator and the RAM pointer.
   localparam int unsigned NIB_W = 4;
   // Accumulator complement.
   localparam logic [9:0] OP_COMPLEMENT_ACC = 10'h01c;
   // Select the RC oscillator as main clock source.
   localparam logic [9:0] OP_SELECT_RC_CLOCK = 10'h29b;
   // Decrement the RAM pointer, skip on wrap.
   localparam logic [9:0] OP_DECREMENT_PTR = 10'h017;
   // Clear the interrupt enable flag.
   localparam logic [9:0] OP_DISABLE_INT = 10'h004;

   // ****************************************************************
   // Values
   // ****************************************************************

   // RAM pointer value after a wrapping decrement.
   localparam logic [3:0] PTR_WRAP_VALUE = 4'hf;
   // Reset values of the held state.
   localparam logic [3:0] ACC_RESET = 4'h0;
   localparam logic [3:0] PTR_RESET = 4'h0;
   localparam logic RC_SEL_RESET = 1'b0;
   localparam logic INT_ENABLE_RESET = 1'b0;
   localparam logic CARRY_RESET = 1'b0;

endpackage : insn_pkg

//--- core/cycle_delay.sv
`timescale 1ns/1ps
`default_nettype none

// Holds a level for one machine cycle: the output follows the input
// only at the end of each executed or skipped machine cycle.
module cycle_delay
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Machine cycle strobe and level.
   input wire logic cycle_end,
   input wire logic level_in,
   // Delayed level.
   output logic level_out
);

   // ****************************************************************
   // Delay stage
   // ****************************************************************

   // Samples the level once per machine cycle.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_out <= 1'b0;
      end
      else if (cycle_end)
      begin
         level_out <= level_in;
      end
   end

endmodule : cycle_delay

`default_nettype wire

//--- core/insn_exec.sv
`timescale 1ns/1ps
`default_nettype none

module insn_exec
   import insn_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Fetched instruction, one machine cycle per valid strobe.
   input wire logic insn_valid,
   input wire logic [9:0] insn_code,
   // Loads from the rest of the core.
   input wire logic acc_load,
   input wire logic [3:0] acc_load_data,
   input wire logic ptr_load,
   input wire logic [3:0] ptr_load_data,
   input wire logic carry_load,
   input wire logic carry_load_data,
   input wire logic int_enable_set,
   // Held state.
   output logic [3:0] accumulator,
   output logic [3:0] ram_pointer,
   output logic carry_flag,
   output logic interrupt_enable_flag,
   output logic rc_clock_select,
   // Skip and interrupt control.
   output logic skip_request,
   output logic skip_pending,
   output logic insn_executed,
   output logic interrupt_accept_enable
);

   // ****************************************************************
   // Decode
   // ****************************************************************

   // Matches an instruction word against one opcode.
   function automatic logic is_op(input logic [9:0] code, input logic [9:0] op);
      is_op = (code == op);
   endfunction : is_op

   // An instruction executes unless the previous one asked to skip it.
   wire logic exec = insn_valid && !skip_pending;
   // One strobe per decoded instruction.
   wire logic complement_accumulator_insn = exec && is_op(insn_code, OP_COMPLEMENT_ACC);
   wire logic select_rc_clock_insn = exec && is_op(insn_code, OP_SELECT_RC_CLOCK);
   wire logic decrement_ram_pointer_insn = exec && is_op(insn_code, OP_DECREMENT_PTR);
   wire logic disable_interrupt_insn = exec && is_op(insn_code, OP_DISABLE_INT);
   // Decremented pointer, kept at four bits so it wraps.
   wire logic [3:0] next_ram_pointer = ram_pointer - 4'h1;
   // The skip comes only from a wrapping decrement.
   wire logic next_skip = decrement_ram_pointer_insn
      && (next_ram_pointer == PTR_WRAP_VALUE);

   assign skip_request = next_skip;
   assign insn_executed = exec;

   // ****************************************************************
   // Datapath registers
   // ****************************************************************

   // Accumulator: a decoded complement wins over an outside load.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accumulator <= ACC_RESET;
      end
      else if (complement_accumulator_insn)
      begin
         accumulator <= ~accumulator;
      end
      else if (acc_load)
      begin
         accumulator <= acc_load_data;
      end
   end

   // RAM pointer: a decoded decrement wins over an outside load.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ram_pointer <= PTR_RESET;
      end
      else if (decrement_ram_pointer_insn)
      begin
         ram_pointer <= next_ram_pointer;
      end
      else if (ptr_load)
      begin
         ram_pointer <= ptr_load_data;
      end
   end

   // Carry changes only by outside load, never by these opcodes.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         carry_flag <= CARRY_RESET;
      end
      else if (carry_load)
      begin
         carry_flag <= carry_load_data;
      end
   end

   // Clock source select is sticky once the RC oscillator is chosen.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rc_clock_select <= RC_SEL_RESET;
      end
      else if (select_rc_clock_insn)
      begin
         rc_clock_select <= 1'b1;
      end
   end

   // Interrupt enable: disable instruction clears, outside set raises.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         interrupt_enable_flag <= INT_ENABLE_RESET;
      end
      else if (disable_interrupt_insn)
      begin
         interrupt_enable_flag <= 1'b0;
      end
      else if (int_enable_set)
      begin
         interrupt_enable_flag <= 1'b1;
      end
   end

   // Skip pending: set by a wrap, consumed by the next fetched word.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         skip_pending <= 1'b0;
      end
      else if (insn_valid)
      begin
         skip_pending <= next_skip;
      end
   end

   // ****************************************************************
   // Interrupt acceptance latency
   // ****************************************************************

   // Acceptance follows the flag one machine cycle late.
   cycle_delay u_accept_delay
   (
      .clk(clk),
      .rst_n(rst_n),
      .cycle_end(insn_valid),
      .level_in(interrupt_enable_flag),
      .level_out(interrupt_accept_enable)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking chk_clk @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   acc_complement_a: assert property (
      complement_accumulator_insn |=> accumulator == ~$past(accumulator))
      else $error("Accumulator not complemented.");

   rc_select_a: assert property (
      select_rc_clock_insn |=> rc_clock_select)
      else $error("RC clock not selected.");

   ptr_decrement_a: assert property (
      decrement_ram_pointer_insn |=> ram_pointer == $past(ram_pointer) - 4'h1)
      else $error("Pointer not decremented.");

   skip_on_wrap_a: assert property (
      decrement_ram_pointer_insn && ram_pointer == 4'h0 |=> skip_pending)
      else $error("Wrapped decrement did not arm the skip.");

   // A pending skip must survive idle cycles until the next word consumes it.
   skip_hold_a: assert property (
      skip_pending && !insn_valid |=> skip_pending)
      else $error("Pending skip lost before the next word.");

   int_clear_a: assert property (
      disable_interrupt_insn |=> !interrupt_enable_flag)
      else $error("Interrupt flag not cleared.");

   accept_latency_a: assert property (
      disable_interrupt_insn && interrupt_accept_enable
      |=> interrupt_accept_enable until_with insn_valid)
      else $error("Acceptance blocked too early.");

   carry_kept_a: assert property (
      !carry_load |=> $stable(carry_flag))
      else $error("Carry changed without load.");

   skip_source_a: assert property (
      skip_request |-> decrement_ram_pointer_insn)
      else $error("Skip from wrong instruction.");

   wrap_skip_c: cover property (decrement_ram_pointer_insn && skip_request);
   disable_int_c: cover property (disable_interrupt_insn ##1 interrupt_accept_enable
      ##[1:4] !interrupt_accept_enable);
   complement_c: cover property (complement_accumulator_insn);
   rc_clock_c: cover property (select_rc_clock_insn);

endmodule : insn_exec

`default_nettype wire

//--- verification/tb_insn_exec.sv
`timescale 1ns/1ps
`default_nettype none

module tb_insn_exec;
   import insn_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************

   // One table row: preload, word, expected state.
   typedef struct packed
   {
      logic [9:0] code;
      logic [3:0] a;
      logic [3:0] p;
      logic [3:0] ea;
      logic [3:0] ep;
      logic sk;
      logic ie;
      logic rc;
   } row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic insn_valid = 1'b0;
   logic [9:0] insn_code = 10'h000;
   logic acc_load = 1'b0;
   logic [3:0] acc_load_data = 4'h0;
   logic ptr_load = 1'b0;
   logic [3:0] ptr_load_data = 4'h0;
   logic carry_load = 1'b0;
   logic carry_load_data = 1'b0;
   logic int_enable_set = 1'b0;
   logic [3:0] accumulator;
   logic [3:0] ram_pointer;
   logic carry_flag;
   logic interrupt_enable_flag;
   logic rc_clock_select;
   logic skip_request;
   logic skip_pending;
   logic insn_executed;
   logic interrupt_accept_enable;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   // Skip request and execute strobe seen in the word's own cycle.
   logic sk;
   logic ex;
   row_t rows [7] = '{
      '{OP_COMPLEMENT_ACC, 4'h5, 4'h3, 4'ha, 4'h3, 1'b0, 1'b1, 1'b0},
      '{OP_COMPLEMENT_ACC, 4'h0, 4'h3, 4'hf, 4'h3, 1'b0, 1'b1, 1'b0},
      '{OP_SELECT_RC_CLOCK, 4'h3, 4'h7, 4'h3, 4'h7, 1'b0, 1'b1, 1'b1},
      '{OP_DECREMENT_PTR, 4'h3, 4'h1, 4'h3, 4'h0, 1'b0, 1'b1, 1'b1},
      '{OP_DECREMENT_PTR, 4'h3, 4'h0, 4'h3, 4'hf, 1'b1, 1'b1, 1'b1},
      '{OP_DECREMENT_PTR, 4'h3, 4'h8, 4'h3, 4'h7, 1'b0, 1'b1, 1'b1},
      '{OP_DISABLE_INT, 4'h9, 4'h2, 4'h9, 4'h2, 1'b0, 1'b0, 1'b1}};

   insn_exec DUT (.clk(clk), .rst_n(rst_n), .insn_valid(insn_valid), .insn_code(insn_code),
      .acc_load(acc_load), .acc_load_data(acc_load_data), .ptr_load(ptr_load),
      .ptr_load_data(ptr_load_data), .carry_load(carry_load),
      .carry_load_data(carry_load_data), .int_enable_set(int_enable_set),
      .accumulator(accumulator),
      .ram_pointer(ram_pointer), .carry_flag(carry_flag),
      .interrupt_enable_flag(interrupt_enable_flag), .rc_clock_select(rc_clock_select),
      .skip_request(skip_request), .skip_pending(skip_pending),
      .insn_executed(insn_executed), .interrupt_accept_enable(interrupt_accept_enable));

   // ****************************************************************
   // Clock, timeout and helpers
   // ****************************************************************

   // The clock toggles every half period of 4 ns.
   always #4 clk = ~clk;

   // A hung run is cut short well after the expected fifty or so cycles.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fail_count = fail_count + 1;
         stop_test();
      end
   end

   // Compares a seen value with the expected one.
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Loads accumulator, pointer and carry, and sets the enable flag.
   task automatic preload(input logic [3:0] a, input logic [3:0] p);
      @(posedge clk);
      {acc_load, ptr_load, carry_load, int_enable_set} <= 4'hf;
      {acc_load_data, ptr_load_data, carry_load_data} <= {a, p, 1'b1};
      @(posedge clk);
      {acc_load, ptr_load, carry_load, int_enable_set} <= 4'h0;
   endtask : preload

   // Presents one word for one machine cycle and records the strobes.
   task automatic exec(input logic [9:0] code);
      @(posedge clk);
      insn_valid <= 1'b1;
      insn_code <= code;
      #1;
      sk = skip_request;
      ex = insn_executed;
      @(posedge clk);
      insn_valid <= 1'b0;
      #1;
   endtask : exec

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // ****************************************************************
   // Tests
   // ****************************************************************

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Table rows; a wrapping decrement is followed by a word that must be skipped.
      foreach (rows[i])
      begin
         preload(rows[i].a, rows[i].p);
         exec(rows[i].code);
         check(sk, rows[i].sk);
         check(skip_pending, rows[i].sk);
         check(accumulator, rows[i].ea);
         check(ram_pointer, rows[i].ep);
         check(carry_flag, 1'b1);
         check(interrupt_enable_flag, rows[i].ie);
         check(rc_clock_select, rows[i].rc);
         if (rows[i].sk)
         begin
            exec(OP_COMPLEMENT_ACC);
            check(ex, 1'b0);
            check(accumulator, rows[i].ea);
         end
         $display("row %0d done", i);
      end
      // Disable takes hold of acceptance only one machine cycle later.
      preload(4'h1, 4'h1);
      exec(OP_COMPLEMENT_ACC);
      check(interrupt_accept_enable, 1'b1);
      exec(OP_DISABLE_INT);
      check(interrupt_enable_flag, 1'b0);
      check(interrupt_accept_enable, 1'b1);
      exec(OP_COMPLEMENT_ACC);
      check(interrupt_accept_enable, 1'b0);
      $display("disable latency done");
      // Reset in mid-run clears the held state.
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      check({accumulator, ram_pointer} !== 8'h00, 1'b0);
      check({carry_flag, interrupt_enable_flag, rc_clock_select, skip_pending}, 4'h0);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      // The first word after release must work from the reset state.
      check(interrupt_accept_enable, 1'b0);
      exec(OP_DECREMENT_PTR);
      check(sk, 1'b1);
      check(ram_pointer, 4'hf);
      check(skip_pending, 1'b1);
      $display("reset done");
      stop_test();
   end

endmodule : tb_insn_exec

`default_nettype wire
